// ==== skip_exec_pkg.sv ====
// package: constants, opcodes and carriers for the skip and table-read executor
// Notes on behaviour
// [RULE_01] plain skip-if-zero reads byte, writes it back, skips when byte is zero
// [RULE_02] skip-with-move copies the byte into the accumulator whatever its value
// [RULE_03] skip-with-move skips the next instruction when the copied byte is zero
// [RULE_04] nonzero value: execution continues with the next instruction, no skip
// [RULE_05] taken skip substitutes a dummy no-operation while next instruction fetches
// [RULE_06] taken skip occupies three instruction cycles in total
// [RULE_07] bit-test skip skips the next instruction when the selected bit is zero
// [RULE_08] table read fetches program word at high and low table pointers in page
// [RULE_09] table read stores low byte of the program word into data memory
// [RULE_10] table read puts high byte of the program word into the high-byte latch
// [RULE_11] skip instructions never modify any status flag
// [RULE_12] untaken skip finishes in its normal cycle count with no dummy cycle
package skip_exec_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int PROG_W = 16;
	localparam int PADDR_W = 16;
	localparam int BIT_W = 3;
	// cycles spent by each instruction
	localparam logic [1:0] CYC_NORMAL = 2'h2;
	localparam logic [1:0] CYC_TAKEN = 2'h3;
	localparam logic [1:0] CYC_RESET = 2'h0;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] TABLE_HIGH_BYTE_LATCH_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_SKIP_ZERO = 3'b001,
		OP_SKIP_ZERO_ACC = 3'b010,
		OP_SKIP_BIT = 3'b011,
		OP_TABLE_READ = 3'b100
	} op_t;

	typedef struct packed {
		op_t op;
		logic [ADDR_W-1:0] addr;
		logic [BIT_W-1:0] bit_sel;
	} instr_t;

	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} dmem_wr_t;
endpackage

// ==== skip_test_unit.sv ====
// module: zero and bit test for skip decisions
`timescale 1ns/1ns
module skip_test_unit (
	input wire logic [7:0] value_in,
	input wire logic [2:0] bit_sel_in,
	input wire logic bit_mode_in,
	output logic is_zero_out
);
	wire byte_zero = (value_in == skip_exec_pkg::ZERO_BYTE);
	wire bit_zero = ~value_in[bit_sel_in];
	assign is_zero_out = bit_mode_in ? bit_zero : byte_zero; // RULE_07
endmodule // skip_test_unit

// ==== skip_and_table_read_exec.sv ====
// module: executes skip-if-zero, skip-with-move, bit-test skip and paged table read
`timescale 1ns/1ns
module skip_and_table_read_exec (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic instr_valid_in,
	input wire skip_exec_pkg::instr_t instr_in,
	input wire logic [7:0] table_pointer_high_in,
	input wire logic [7:0] table_pointer_low_in,
	input wire logic [7:0] dmem_rdata_in,
	input wire logic [15:0] pmem_rdata_in,
	output logic busy_out,
	output logic [7:0] dmem_raddr_out,
	output skip_exec_pkg::dmem_wr_t dmem_wr_out,
	output logic [15:0] pmem_addr_out,
	output logic [7:0] accumulator_register_out,
	output logic [7:0] table_high_byte_latch_out,
	output logic dummy_nop_out,
	output logic skip_taken_out,
	output logic flags_we_out,
	output logic done_out,
	output logic [1:0] cycles_out
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_DUMMY = 2'b10
	} state_t;

	state_t state_q;
	state_t state_d;
	skip_exec_pkg::instr_t cur_q;
	logic [7:0] acc_q;
	logic [7:0] table_high_byte_latch_q;
	skip_exec_pkg::dmem_wr_t wr_q;
	logic dummy_q;
	logic skip_q;
	logic done_q;
	logic [1:0] cyc_q;
	logic is_zero;
	skip_exec_pkg::instr_t cur_d;
	skip_exec_pkg::dmem_wr_t wr_d;
	logic [7:0] wr_data;
	logic wr_en;
	logic [7:0] acc_d;
	logic [7:0] table_high_byte_latch_d;
	logic fin_plain;
	logic fin_dummy;
	logic done_d;
	logic [1:0] cyc_d;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire start = (state_q == ST_IDLE) && instr_valid_in &&
		(instr_in.op != skip_exec_pkg::OP_NONE);
	wire op_sz = (cur_q.op == skip_exec_pkg::OP_SKIP_ZERO);
	wire op_sza = (cur_q.op == skip_exec_pkg::OP_SKIP_ZERO_ACC);
	wire op_sb = (cur_q.op == skip_exec_pkg::OP_SKIP_BIT);
	wire op_tr = (cur_q.op == skip_exec_pkg::OP_TABLE_READ);
	wire in_exec = (state_q == ST_EXEC);
	wire skip_op = op_sz || op_sza || op_sb;
	// a nonzero test falls through, so the next instruction runs unskipped
	wire take = in_exec && skip_op && is_zero; // RULE_04

	skip_test_unit u_test (
		.value_in(dmem_rdata_in),
		.bit_sel_in(cur_q.bit_sel),
		.bit_mode_in(op_sb),
		.is_zero_out(is_zero)
	);

	// memory read address chosen in the exec cycle
	assign dmem_raddr_out = cur_q.addr;
	assign pmem_addr_out = {table_pointer_high_in, table_pointer_low_in}; // RULE_08
	assign busy_out = (state_q != ST_IDLE);
	// no flag path at all: a skip must never disturb the status bits
	assign flags_we_out = 1'b0; // RULE_11

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				state_d = take ? ST_DUMMY : ST_IDLE; // RULE_05 RULE_12
			end
			ST_DUMMY: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// state and latched instruction
	// ------------------------------------------------------------
	// the word is held for the exec cycle so fetch may already move on
	assign cur_d = start ? instr_in : cur_q;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cur_q <= '0;
		end else begin
			cur_q <= cur_d;
		end
	end

	// ------------------------------------------------------------
	// data-memory write-back
	// ------------------------------------------------------------
	// plain skip rewrites the byte unchanged, table read writes its low byte
	assign wr_data = op_tr ? pmem_rdata_in[7:0] : dmem_rdata_in; // RULE_01 RULE_09
	// move-skip and bit-test leave memory alone, so no needless write
	assign wr_en = in_exec && (op_sz || op_tr);
	assign wr_d = '{
		we: wr_en,
		addr: cur_q.addr,
		wdata: wr_data
	};

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_q <= '0;
		end else begin
			wr_q <= wr_d;
		end
	end

	// ------------------------------------------------------------
	// accumulator and table high-byte latch
	// ------------------------------------------------------------
	// the move copies every byte, zero too, on the same edge that registers the skip
	assign acc_d = (in_exec && op_sza) ? dmem_rdata_in : acc_q; // RULE_02
	// high byte latches on the edge that registers the low-byte write; data memory takes the low byte one edge later
	assign table_high_byte_latch_d = (in_exec && op_tr) ? pmem_rdata_in[15:8] : table_high_byte_latch_q; // RULE_10

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			acc_q <= skip_exec_pkg::ACC_RESET;
		end else begin
			acc_q <= acc_d;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			table_high_byte_latch_q <= skip_exec_pkg::TABLE_HIGH_BYTE_LATCH_RESET;
		end else begin
			table_high_byte_latch_q <= table_high_byte_latch_d;
		end
	end

	// ------------------------------------------------------------
	// completion and cycle count
	// ------------------------------------------------------------
	assign fin_plain = in_exec && !take;
	assign fin_dummy = (state_q == ST_DUMMY);
	assign done_d = fin_plain || fin_dummy;
	// the count holds after done so a slow reader still sees it
	assign cyc_d = fin_dummy ? skip_exec_pkg::CYC_TAKEN : // RULE_06
		(fin_plain ? skip_exec_pkg::CYC_NORMAL : cyc_q); // RULE_12

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dummy_q <= 1'b0;
		end else begin
			dummy_q <= take; // RULE_05
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			skip_q <= 1'b0;
		end else begin
			skip_q <= take; // RULE_03 RULE_07
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done_d;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cyc_q <= skip_exec_pkg::CYC_RESET;
		end else begin
			cyc_q <= cyc_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign dmem_wr_out = wr_q;
	assign accumulator_register_out = acc_q;
	assign table_high_byte_latch_out = table_high_byte_latch_q;
	assign dummy_nop_out = dummy_q;
	assign skip_taken_out = skip_q;
	assign done_out = done_q;
	assign cycles_out = cyc_q;
endmodule // skip_and_table_read_exec

// ==== mem_model.sv ====
// partner model: data memory and program memory
`timescale 1ns/1ns
module mem_model (
	input wire logic clk_in,
	input wire logic [7:0] raddr_in,
	input wire skip_exec_pkg::dmem_wr_t wr_in,
	input wire logic [15:0] paddr_in,
	output logic [7:0] rdata_out,
	output logic [15:0] pdata_out
);
	logic [7:0] mem [256];
	// combinational reads, as the core expects
	assign rdata_out = mem[raddr_in];
	// word made from its address so every pointer bit shows
	assign pdata_out = paddr_in ^ 16'hA55A;
	always @(posedge clk_in) begin
		if (wr_in.we) begin
			mem[wr_in.addr] <= wr_in.wdata;
		end
	end
endmodule // mem_model

// ==== skip_exec_asserts.sv ====
// checker: skip and table-read timing at the ports
`timescale 1ns/1ns
module skip_exec_asserts (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic instr_valid_in,
	input wire skip_exec_pkg::instr_t instr_in,
	input wire logic [7:0] table_pointer_high_in,
	input wire logic [7:0] table_pointer_low_in,
	input wire logic [7:0] dmem_rdata_in,
	input wire logic [15:0] pmem_rdata_in,
	input wire logic busy_out,
	input wire skip_exec_pkg::dmem_wr_t dmem_wr_out,
	input wire logic [15:0] pmem_addr_out,
	input wire logic [7:0] accumulator_register_out,
	input wire logic [7:0] table_high_byte_latch_out,
	input wire logic dummy_nop_out,
	input wire logic skip_taken_out,
	input wire logic flags_we_out,
	input wire logic done_out,
	input wire logic [1:0] cycles_out
);
	skip_exec_pkg::instr_t ex_q;
	logic [7:0] rd_q;
	logic [15:0] pm_q;
	logic bz_q;
	wire st = !busy_out && instr_valid_in && instr_in.op != skip_exec_pkg::OP_NONE;
	// instruction in its exec cycle, none otherwise
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ex_q <= '0;
		end else begin
			ex_q <= st ? instr_in : '0;
		end
	end
	always_ff @(posedge clk_in) begin
		rd_q <= dmem_rdata_in;
		pm_q <= pmem_rdata_in;
		bz_q <= dmem_rdata_in[ex_q.bit_sel];
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	skip_wb_a: assert property (ex_q.op == skip_exec_pkg::OP_SKIP_ZERO |=>
		dmem_wr_out.we && dmem_wr_out.wdata == rd_q) else $error("bad write-back");
	acc_move_a: assert property (ex_q.op == skip_exec_pkg::OP_SKIP_ZERO_ACC |=>
		accumulator_register_out == rd_q) else $error("bad acc copy");
	zero_skip_a: assert property (ex_q.op inside {skip_exec_pkg::OP_SKIP_ZERO,
		skip_exec_pkg::OP_SKIP_ZERO_ACC} |=> skip_taken_out == (rd_q == 8'h00))
		else $error("bad zero skip");
	bit_skip_a: assert property (ex_q.op == skip_exec_pkg::OP_SKIP_BIT |=>
		skip_taken_out == !bz_q) else $error("bad bit skip");
	table_read_a: assert property (ex_q.op == skip_exec_pkg::OP_TABLE_READ |->
		pmem_addr_out == {table_pointer_high_in, table_pointer_low_in} ##1 dmem_wr_out.we
		&& dmem_wr_out.wdata == pm_q[7:0] && table_high_byte_latch_out == pm_q[15:8])
		else $error("bad table read");
	dummy_cycle_a: assert property (skip_taken_out |-> dummy_nop_out && busy_out
		##1 done_out && cycles_out == skip_exec_pkg::CYC_TAKEN) else $error("bad taken skip");
	no_dummy_a: assert property (ex_q.op != skip_exec_pkg::OP_NONE ##1 !skip_taken_out |->
		done_out && !dummy_nop_out && cycles_out == skip_exec_pkg::CYC_NORMAL)
		else $error("bad untaken skip");
	no_flags_a: assert property (!flags_we_out) else $error("flag write");
	cover property (skip_taken_out);
	cover property (ex_q.op == skip_exec_pkg::OP_TABLE_READ);
	cover property (done_out && cycles_out == skip_exec_pkg::CYC_NORMAL);
endmodule // skip_exec_asserts
bind skip_and_table_read_exec skip_exec_asserts A (.clk_in, .rst_in, .instr_valid_in, .instr_in,
	.table_pointer_high_in, .table_pointer_low_in, .dmem_rdata_in, .pmem_rdata_in, .busy_out,
	.dmem_wr_out, .pmem_addr_out, .accumulator_register_out, .table_high_byte_latch_out,
	.dummy_nop_out, .skip_taken_out, .flags_we_out, .done_out, .cycles_out);

// ==== testbench.sv ====
// testbench: directed scenarios for the skip and table-read executor
`timescale 1ns/1ns
module testbench;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic instr_valid_in = 1'b0;
	skip_exec_pkg::instr_t instr_in = '0;
	logic [7:0] table_pointer_high_in = 8'h12;
	logic [7:0] table_pointer_low_in = 8'h34;
	logic [7:0] dmem_rdata_in, dmem_raddr_out, accumulator_register_out, table_high_byte_latch_out;
	logic [15:0] pmem_rdata_in, pmem_addr_out;
	skip_exec_pkg::dmem_wr_t dmem_wr_out;
	logic busy_out, dummy_nop_out, skip_taken_out, flags_we_out, done_out, sk, dm;
	logic [1:0] cycles_out;
	int miscompares = 0;
	int n_checks = 0;
	always #4 clk_in = ~clk_in;
	skip_and_table_read_exec DUT (.clk_in, .rst_in, .instr_valid_in, .instr_in,
		.table_pointer_high_in, .table_pointer_low_in, .dmem_rdata_in, .pmem_rdata_in,
		.busy_out, .dmem_raddr_out, .dmem_wr_out, .pmem_addr_out, .accumulator_register_out,
		.table_high_byte_latch_out, .dummy_nop_out, .skip_taken_out, .flags_we_out,
		.done_out, .cycles_out);
	mem_model M (.clk_in, .raddr_in(dmem_raddr_out), .wr_in(dmem_wr_out),
		.paddr_in(pmem_addr_out), .rdata_out(dmem_rdata_in), .pdata_out(pmem_rdata_in));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// issue one instruction, note any skip, wait for done
	task automatic run(input skip_exec_pkg::op_t op, input logic [7:0] a, input logic [2:0] b);
		@(posedge clk_in);
		#1 instr_valid_in = 1'b1;
		instr_in = '{op, a, b};
		@(posedge clk_in);
		#1 instr_valid_in = 1'b0;
		sk = 1'b0;
		dm = 1'b0;
		for (int i = 0; i < 8 && done_out !== 1'b1; i++) begin
			@(posedge clk_in);
			#1 sk = sk | skip_taken_out;
			dm = dm | dummy_nop_out;
		end
		if (done_out !== 1'b1) begin
			miscompares++;
			report_and_stop();
		end
	endtask
	task automatic t_skip_zero();
		M.mem[8'h10] = 8'h00;
		M.mem[8'h11] = 8'h5A;
		run(skip_exec_pkg::OP_SKIP_ZERO, 8'h10, 3'h0);
		chk(8'(sk), 8'h01);
		chk(8'(cycles_out), 8'h03);
		chk(8'(dm), 8'h01);
		run(skip_exec_pkg::OP_SKIP_ZERO, 8'h11, 3'h0);
		chk(8'(sk), 8'h00);
		chk(8'(cycles_out), 8'h02);
		chk(8'(dm), 8'h00);
		chk(8'(dmem_wr_out.we), 8'h01);
		chk(dmem_wr_out.wdata, 8'h5A);
		@(posedge clk_in);
		#1 chk(M.mem[8'h11], 8'h5A);
		$display("t_skip_zero done");
	endtask
	task automatic t_acc();
		M.mem[8'h12] = 8'hC3;
		M.mem[8'h13] = 8'h00;
		run(skip_exec_pkg::OP_SKIP_ZERO_ACC, 8'h12, 3'h0);
		chk(accumulator_register_out, 8'hC3);
		chk(8'(sk), 8'h00);
		run(skip_exec_pkg::OP_SKIP_ZERO_ACC, 8'h13, 3'h0);
		chk(accumulator_register_out, 8'h00);
		chk(8'(sk), 8'h01);
		$display("t_acc done");
	endtask
	task automatic t_bit();
		M.mem[8'h14] = 8'hF7;
		run(skip_exec_pkg::OP_SKIP_BIT, 8'h14, 3'h3);
		chk(8'(sk), 8'h01);
		run(skip_exec_pkg::OP_SKIP_BIT, 8'h14, 3'h0);
		chk(8'(sk), 8'h00);
		$display("t_bit done");
	endtask
	task automatic t_table();
		run(skip_exec_pkg::OP_TABLE_READ, 8'h15, 3'h0);
		chk(table_high_byte_latch_out, 8'hB7);
		chk(8'(flags_we_out), 8'h00);
		@(posedge clk_in);
		#1 chk(M.mem[8'h15], 8'h6E);
		$display("t_table done");
	endtask
	initial begin
		repeat (4) @(posedge clk_in);
		#1 rst_in = 1'b0;
		t_skip_zero();
		t_acc();
		t_bit();
		t_table();
		report_and_stop();
	end
endmodule // testbench
